// ===== inc/rac_pkg.sv
// package: shared types and constants of the register access bank
package rac_pkg;

    // bus widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;

    // register indices on the peripheral access port
    localparam logic [2:0] OFS_BASE     = 3'h0;  // base register of the pair
    localparam logic [2:0] OFS_BASE_SET = 3'h1;  // set alias
    localparam logic [2:0] OFS_BASE_CLR = 3'h2;  // bit_clear_alias
    localparam logic [2:0] OFS_BASE_INV = 3'h3;  // bit_invert_alias
    localparam logic [2:0] OFS_STATUS   = 3'h4;  // read-only status
    localparam logic [2:0] OFS_CTRL     = 3'h5;  // control: rw field, wo command
    localparam logic [2:0] OFS_DEBUG    = 3'h6;  // debug control

    // field layout of the control register
    localparam int unsigned CTRL_FIELD_LSB = 0;  // rw field low bit
    localparam int unsigned CTRL_FIELD_W   = 4;  // rw field width
    localparam int unsigned CTRL_CMD_LSB   = 4;  // wo command low bit
    localparam int unsigned CTRL_CMD_W     = 2;  // wo command width

    // field layout of the status register
    localparam int unsigned STATUS_W = 3;        // live bits, rest reserved

    // reset values
    localparam logic [7:0] BASE_RST  = 8'h00;
    localparam logic [3:0] CTRL_RST  = 4'h0;
    localparam logic [7:0] DEBUG_RST = 8'h00;

    // update kinds applied to a storage cell
    typedef enum logic [1:0]
    {
        RAC_OP_WRITE = 2'h0,  // plain store
        RAC_OP_SET   = 2'h1,  // or in ones
        RAC_OP_CLR   = 2'h2,  // clear where one
        RAC_OP_INV   = 2'h3   // invert where one
    } rac_op_t;

    // one access request
    typedef struct packed
    {
        logic              valid;  // access strobe
        logic              write;  // 1 write, 0 read
        logic [ADDR_W-1:0] addr;   // register index
        logic [DATA_W-1:0] wdata;  // write data
    } rac_req_t;

    // read answer
    typedef struct packed
    {
        logic              rvalid;  // read data valid pulse
        logic [DATA_W-1:0] rdata;   // read data
    } rac_rsp_t;

endpackage : rac_pkg

// ===== rtl/rac_bank.sv
// file: register bank showing the common bit access conventions
// Notes on behaviour
// - read/write bits read back what was written
// - read-only bits ignore writes
// - write-only bits accept writes, reads undefined
// - reserved bits always read zero
// - reset values on power-on and soft reset; debug control reset on power-on only
// - base and alias addresses read same value
// - one in clear alias clears bit
// - one in set alias sets bit
// - one in invert alias toggles bit
`timescale 1ns/1ps
module rac_bank
(
    // clock and resets
    input  wire logic                                    core_clk,
    input  wire logic                                    reset_n,
    input  wire logic                                    soft_reset,
    // peripheral access port
    input  wire rac_pkg::rac_req_t                       req,
    output rac_pkg::rac_rsp_t                            rsp,
    // live status from block logic on this clock
    input  wire logic [rac_pkg::STATUS_W-1:0]            status_in,
    // register contents towards block logic
    output logic      [rac_pkg::DATA_W-1:0]              base_value,
    output logic      [rac_pkg::CTRL_FIELD_W-1:0]        ctrl_field,
    output logic      [rac_pkg::DATA_W-1:0]              debug_value,
    output logic      [rac_pkg::CTRL_CMD_W-1:0]          cmd_pulse
);

    // whole state of the bank besides the cells
    typedef struct packed
    {
        logic                              rvalid;  // read answer pulse
        logic [rac_pkg::DATA_W-1:0]        rdata;   // read answer data
        logic [rac_pkg::CTRL_CMD_W-1:0]    cmd;     // write-only command pulses
    } rac_bank_state_t;

    rac_bank_state_t state_q;  // registered state
    rac_bank_state_t state_d;  // next state

    logic                               wr;         // write strobe
    logic                               base_en;    // update of the pair
    rac_pkg::rac_op_t                   base_op;    // kind of pair update
    logic                               ctrl_en;    // control write
    logic                               debug_en;   // debug write
    logic [rac_pkg::DATA_W-1:0]         rd_mux;     // read selection
    logic [rac_pkg::CTRL_FIELD_W-1:0]   ctrl_wdat;  // rw field of write data

    assign wr        = req.valid && req.write;
    assign ctrl_wdat = req.wdata[rac_pkg::CTRL_FIELD_LSB +: rac_pkg::CTRL_FIELD_W];

    // decode writes onto the pair and its aliases
    always_comb
    begin
        base_en  = 1'b0;
        base_op  = rac_pkg::RAC_OP_WRITE;
        ctrl_en  = wr && (req.addr == rac_pkg::OFS_CTRL);
        debug_en = wr && (req.addr == rac_pkg::OFS_DEBUG);
        if (wr)
        begin
            case (req.addr)
                rac_pkg::OFS_BASE:
                begin
                    base_en = 1'b1;
                    base_op = rac_pkg::RAC_OP_WRITE;
                end
                rac_pkg::OFS_BASE_SET:
                begin
                    base_en = 1'b1;
                    base_op = rac_pkg::RAC_OP_SET;
                end
                rac_pkg::OFS_BASE_CLR:
                begin
                    base_en = 1'b1;
                    base_op = rac_pkg::RAC_OP_CLR;
                end
                rac_pkg::OFS_BASE_INV:
                begin
                    base_en = 1'b1;
                    base_op = rac_pkg::RAC_OP_INV;
                end
                default:
                begin
                    base_en = 1'b0;  // status, control, debug and unmapped: pair not written
                    base_op = rac_pkg::RAC_OP_WRITE;
                end
            endcase
        end
    end

    // base register shared by the pair
    rac_cell
    #(
        .WIDTH        (rac_pkg::DATA_W),
        .RESET_VAL    (rac_pkg::BASE_RST),
        .KEEP_ON_SOFT (1'b0)
    )
    u_base
    (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .soft_reset (soft_reset),
        .upd_en     (base_en),
        .upd_op     (base_op),
        .upd_data   (req.wdata),
        .value      (base_value)
    );

    // read/write field of the control register
    rac_cell
    #(
        .WIDTH        (rac_pkg::CTRL_FIELD_W),
        .RESET_VAL    (rac_pkg::CTRL_RST),
        .KEEP_ON_SOFT (1'b0)
    )
    u_ctrl
    (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .soft_reset (soft_reset),
        .upd_en     (ctrl_en),
        .upd_op     (rac_pkg::RAC_OP_WRITE),
        .upd_data   (ctrl_wdat),
        .value      (ctrl_field)
    );

    // debug control survives a soft reset
    rac_cell
    #(
        .WIDTH        (rac_pkg::DATA_W),
        .RESET_VAL    (rac_pkg::DEBUG_RST),
        .KEEP_ON_SOFT (1'b1)
    )
    u_debug
    (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .soft_reset (soft_reset),
        .upd_en     (debug_en),
        .upd_op     (rac_pkg::RAC_OP_WRITE),
        .upd_data   (req.wdata),
        .value      (debug_value)
    );

    // read selection; reserved and write-only bits give zero
    always_comb
    begin
        rd_mux = '0;
        case (req.addr)
            rac_pkg::OFS_BASE,
            rac_pkg::OFS_BASE_SET,
            rac_pkg::OFS_BASE_CLR,
            rac_pkg::OFS_BASE_INV:
            begin
                rd_mux = base_value;
            end
            rac_pkg::OFS_STATUS:
            begin
                rd_mux[rac_pkg::STATUS_W-1:0] = status_in;
            end
            rac_pkg::OFS_CTRL:
            begin
                // command bits are not stored, upper bits reserved
                rd_mux[rac_pkg::CTRL_FIELD_LSB +: rac_pkg::CTRL_FIELD_W] = ctrl_field;
            end
            rac_pkg::OFS_DEBUG:
            begin
                rd_mux = debug_value;
            end
            default:
            begin
                rd_mux = '0;  // unmapped index reads zero
            end
        endcase
    end

    // answer and command pulse next state
    always_comb
    begin
        state_d        = state_q;
        state_d.rvalid = req.valid && !req.write;
        if (req.valid && !req.write)
        begin
            state_d.rdata = rd_mux;
        end
        // write-only command bits pulse one cycle on a write of one
        state_d.cmd = '0;
        if (ctrl_en && !soft_reset)
        begin
            state_d.cmd = req.wdata[rac_pkg::CTRL_CMD_LSB +: rac_pkg::CTRL_CMD_W];
        end
    end

    // state registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // outputs from flops
    assign rsp = '{rvalid: state_q.rvalid,
                   rdata:  state_q.rdata};  // one driver for the whole answer
    assign cmd_pulse  = state_q.cmd;

endmodule : rac_bank

// ===== rtl/rac_cell.sv
// file: one storage cell with reset values and set/clear/invert updates
`timescale 1ns/1ps
module rac_cell
#(
    parameter int unsigned      WIDTH        = 8,
    parameter logic [WIDTH-1:0] RESET_VAL    = '0,
    parameter bit               KEEP_ON_SOFT = 1'b0
)
(
    // clock and resets
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic                soft_reset,
    // update port
    input  wire logic                upd_en,
    input  wire rac_pkg::rac_op_t    upd_op,
    input  wire logic [WIDTH-1:0]    upd_data,
    // stored value
    output logic      [WIDTH-1:0]    value
);

    // whole state of the cell
    typedef struct packed
    {
        logic [WIDTH-1:0] val;  // stored bits
    } rac_cell_state_t;

    rac_cell_state_t state_q;  // registered state
    rac_cell_state_t state_d;  // next state

    // next value: soft reset wins over the update unless KEEP_ON_SOFT
    always_comb
    begin
        state_d = state_q;
        if (soft_reset && !KEEP_ON_SOFT)
        begin
            state_d.val = RESET_VAL;
        end
        else if (upd_en)
        begin
            case (upd_op)
                rac_pkg::RAC_OP_WRITE: state_d.val = upd_data;
                rac_pkg::RAC_OP_SET:   state_d.val = state_q.val | upd_data;
                rac_pkg::RAC_OP_CLR:   state_d.val = state_q.val & ~upd_data;
                rac_pkg::RAC_OP_INV:   state_d.val = state_q.val ^ upd_data;
                default:               state_d.val = state_q.val;
            endcase
        end
    end

    // storage, power-on value under reset
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q.val <= RESET_VAL;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign value = state_q.val;

endmodule : rac_cell

// ===== verification/rac_bank_checker.sv
// port assertions of the register access bank
`timescale 1ns/1ps
module rac_bank_checker
(
    // clock and resets
    input wire logic                         core_clk,
    input wire logic                         reset_n,
    input wire logic                         soft_reset,
    // access port
    input wire rac_pkg::rac_req_t            req,
    input wire rac_pkg::rac_rsp_t            rsp,
    input wire logic [rac_pkg::STATUS_W-1:0] status_in,
    // register contents
    input wire logic [7:0]                   base_value,
    input wire logic [3:0]                   ctrl_field,
    input wire logic [7:0]                   debug_value,
    input wire logic [1:0]                   cmd_pulse
);
    // single domain, power-on reset disables all
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic rd;     // read taken
    logic wr_ok;  // write taken, no soft reset
    assign rd    = req.valid && !req.write;
    assign wr_ok = req.valid && req.write && !soft_reset;
    chk_rd_answer:
    assert property (rd |=> rsp.rvalid) else $error("read not answered");
    chk_alias_read:
    assert property (rd && req.addr <= rac_pkg::OFS_BASE_INV |=> rsp.rdata == $past(base_value))
        else $error("pair read differs from base");
    chk_status_ro:
    assert property (rd && req.addr == rac_pkg::OFS_STATUS |=> rsp.rdata == {5'h00, $past(status_in)})
        else $error("status read wrong");
    chk_base_write:
    assert property (wr_ok && req.addr == rac_pkg::OFS_BASE |=> base_value == $past(req.wdata))
        else $error("base write lost");
    chk_set_bit:
    assert property (wr_ok && req.addr == rac_pkg::OFS_BASE_SET
        |=> base_value == ($past(base_value) | $past(req.wdata))) else $error("set alias wrong");
    chk_clr_bit:
    assert property (wr_ok && req.addr == rac_pkg::OFS_BASE_CLR
        |=> base_value == ($past(base_value) & ~$past(req.wdata))) else $error("clear alias wrong");
    chk_inv_bit:
    assert property (wr_ok && req.addr == rac_pkg::OFS_BASE_INV
        |=> base_value == ($past(base_value) ^ $past(req.wdata))) else $error("invert alias wrong");
    chk_base_hold:
    assert property (!(req.valid && req.write && req.addr <= rac_pkg::OFS_BASE_INV) && !soft_reset
        |=> $stable(base_value)) else $error("base changed unasked");
    chk_soft_reset:
    assert property (soft_reset && !(req.valid && req.write && req.addr == rac_pkg::OFS_DEBUG)
        |=> base_value == rac_pkg::BASE_RST && ctrl_field == rac_pkg::CTRL_RST
        && cmd_pulse == 2'h0 && $stable(debug_value)) else $error("soft reset wrong");
    chk_cmd_pulse:
    assert property (wr_ok && req.addr == rac_pkg::OFS_CTRL |=> cmd_pulse == $past(req.wdata[5:4])
        && ctrl_field == $past(req.wdata[3:0])) else $error("control write wrong");
endmodule : rac_bank_checker

bind rac_bank rac_bank_checker u_chk
(
    .core_clk, .reset_n, .soft_reset, .req, .rsp, .status_in,
    .base_value, .ctrl_field, .debug_value, .cmd_pulse
);

// ===== verification/tb_rac_bank.sv
// self-checking bench of the register access bank
`timescale 1ns/1ps
module tb_rac_bank;
    logic                         core_clk;     // 100 MHz clock
    logic                         reset_n;      // power-on reset
    logic                         soft_reset;   // peripheral soft reset
    rac_pkg::rac_req_t            req;          // access request
    rac_pkg::rac_rsp_t            rsp;          // read answer
    logic [rac_pkg::STATUS_W-1:0] status_in;    // live status
    logic [7:0]                   base_value;   // base contents
    logic [3:0]                   ctrl_field;   // control field
    logic [7:0]                   debug_value;  // debug contents
    logic [1:0]                   cmd_pulse;    // command pulse
    logic [7:0]                   m_base;       // model of base
    logic [7:0]                   m_dbg;        // model of debug
    logic [3:0]                   m_ctrl;       // model of control field
    logic [1:0]                   m_cmd;        // expected command pulse
    logic [7:0]                   exp_rd;       // expected read data
    logic [7:0]                   rd_msk;       // defined read bits
    logic                         rd_due;       // read answer expected
    logic [31:0]                  r;            // random draw
    int                           miscompares;  // mismatches
    int                           cmp_count;    // comparisons
    int                           seed;         // random seed

    rac_bank u_dut (.core_clk, .reset_n, .soft_reset, .req, .rsp, .status_in,
                    .base_value, .ctrl_field, .debug_value, .cmd_pulse);

    // clock generation
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // compare a register output
    task cmp_out(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_out

    // compare a read answer on its defined bits
    task cmp_rd;
        cmp_count++;
        if (rsp.rvalid !== 1'b1 || (rsp.rdata & rd_msk) !== (exp_rd & rd_msk))
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t read got %h exp %h", $time, rsp.rdata, exp_rd);
        end
    endtask : cmp_rd

    // expected read value from the model
    function automatic logic [7:0] rd_value(input logic [2:0] a);
        if (a <= rac_pkg::OFS_BASE_INV) return m_base;
        case (a)
            rac_pkg::OFS_STATUS: return {5'h00, status_in};
            rac_pkg::OFS_CTRL:   return {4'h0, m_ctrl};
            rac_pkg::OFS_DEBUG:  return m_dbg;
            default:             return 8'h00;
        endcase
    endfunction : rd_value

    // check last edge, then drive one access for the next
    task step(input logic sr, input logic v, input logic w, input logic [2:0] a,
              input logic [7:0] d);
        @(negedge core_clk);
        cmp_out(base_value, m_base, "base");
        cmp_out({4'h0, ctrl_field}, {4'h0, m_ctrl}, "ctrl");
        cmp_out(debug_value, m_dbg, "debug");
        cmp_out({6'h00, cmd_pulse}, {6'h00, m_cmd}, "cmd");
        if (rd_due) cmp_rd;
        else cmp_out({7'h00, rsp.rvalid}, 8'h00, "rvalid");
        soft_reset = sr;
        req = '{valid: v, write: w, addr: a, wdata: d};
        status_in = 3'($random(seed));
        rd_due = v && !w;
        exp_rd = rd_value(a);
        rd_msk = (a == rac_pkg::OFS_CTRL) ? 8'hCF : 8'hFF;  // write-only bits undefined
        m_cmd = 2'h0;
        if (v && w)
            case (a)
                rac_pkg::OFS_BASE:     m_base = d;
                rac_pkg::OFS_BASE_SET: m_base = m_base | d;
                rac_pkg::OFS_BASE_CLR: m_base = m_base & ~d;
                rac_pkg::OFS_BASE_INV: m_base = m_base ^ d;
                rac_pkg::OFS_CTRL:     {m_cmd, m_ctrl} = d[5:0];
                rac_pkg::OFS_DEBUG:    m_dbg = d;
                default:               m_cmd = 2'h0;
            endcase
        if (sr) {m_base, m_ctrl, m_cmd} = {rac_pkg::BASE_RST, rac_pkg::CTRL_RST, 2'h0};
    endtask : step

    // power-on reset, outputs and model to reset values
    task do_reset;
        @(negedge core_clk);
        {reset_n, soft_reset, req, rd_due, m_cmd} = '0;
        {m_base, m_ctrl, m_dbg} = {rac_pkg::BASE_RST, rac_pkg::CTRL_RST, rac_pkg::DEBUG_RST};
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
    endtask : do_reset

    // print counts and verdict, end the run
    task wrap_up;
        $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // watchdog against a hang
    initial
    begin
        #60000;
        miscompares++;
        wrap_up;
    end

    // main sequence
    initial
    begin
        seed = 56;
        miscompares = 0;
        cmp_count = 0;
        status_in = '0;
        reset_n = 1'h0;  // hold the design in reset from time zero
        do_reset;
        step(1'h0, 1'h1, 1'h1, rac_pkg::OFS_BASE, 8'hA5);
        step(1'h0, 1'h1, 1'h1, rac_pkg::OFS_BASE_SET, 8'h5A);
        step(1'h0, 1'h1, 1'h1, rac_pkg::OFS_BASE_CLR, 8'h0F);
        step(1'h0, 1'h1, 1'h1, rac_pkg::OFS_BASE_INV, 8'h3C);
        step(1'h0, 1'h1, 1'h1, rac_pkg::OFS_CTRL, 8'h3A);
        step(1'h0, 1'h1, 1'h1, rac_pkg::OFS_CTRL, 8'hFF);
        step(1'h0, 1'h1, 1'h1, rac_pkg::OFS_STATUS, 8'hFF);
        step(1'h0, 1'h1, 1'h1, rac_pkg::OFS_DEBUG, 8'h77);
        for (int i = 0; i < 8; i++) step(1'h0, 1'h1, 1'h0, i[2:0], 8'h00);
        step(1'h1, 1'h1, 1'h1, rac_pkg::OFS_BASE, 8'hFF);
        for (int i = 0; i < 4000; i++)
        begin
            r = $random(seed);
            step(r[3:0] == 4'h0, r[4] | r[5], r[6], r[9:7], r[17:10]);
        end
        step(1'h0, 1'h0, 1'h0, 3'h0, 8'h00);
        do_reset;
        for (int i = 0; i < 8; i++) step(1'h0, 1'h1, 1'h0, i[2:0], 8'h00);
        step(1'h0, 1'h0, 1'h0, 3'h0, 8'h00);
        wrap_up;
    end
endmodule : tb_rac_bank
